// >>> rtl/cts_timer16.sv
// Purpose: two 8-bit counters cascaded into a 16-bit timer, event
//          counter and pwm generator
// Assumes: software writes one byte per reg_wr pulse, low byte first
// Notes: readback ports are the live registers, except count_value, a registered copy of the counter
`timescale 1ns/1ps
// Behaviour
// - timer mode: cascaded 16-bit prescaled up-counter
// - run set: period match interrupts, clears, continues
// - period unbuffered, takes effect immediately
// - timer sources fc/2^11 or fs/8, 2^7, 2^5, 2^3
// - event mode counts count pin falling edges
// - pwm duty match toggles output flip-flop
// - overflow toggles, clears, raises cascade interrupt
// - flip-flop loadable from init bit, reset zero
// - pwm pin is inverse of flip-flop
// - running duty writes buffered until interrupt
// - duty readback shows value in effect
// - stop freezes pin; init bit after stop
// - pwm adds fs, fc/2, fc sources
module cts_timer16
    import cts_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // register writes, one byte per pulse
    input wire cts_wr_t reg_wr,
    // clock environment
    input wire logic divider_stage_select,
    input wire logic low_freq_mode,
    input wire logic fs_tick,
    // link pins
    input wire logic count_input_pin,
    output logic pwm_output_pin,
    // events
    output logic cascade_interrupt,
    // readback
    output logic [7:0] lower_unit_control,
    output logic [7:0] upper_unit_control,
    output logic [15:0] period_reg,
    output logic [15:0] duty_reg,
    output logic [15:0] count_value,
    output logic output_flipflop
);
    logic [7:0] duty_stage_low;
    logic [15:0] duty_shift;
    logic [7:0] count_low;
    logic [7:0] count_high;
    logic tick;
    cts_mode_t mode;
    logic running;

    logic [7:0] next_lower_ctl;
    logic [7:0] next_upper_ctl;
    logic [15:0] next_period;
    logic [15:0] next_duty;
    logic [7:0] next_duty_stage_low;
    logic [15:0] next_duty_shift;
    logic [7:0] next_count_low;
    logic [7:0] next_count_high;
    logic next_ff;
    logic next_irq;
    logic next_pin;

    cts_prescaler u_prescaler (
        .clock(clock),
        .rst(rst),
        .clock_select(lower_unit_control[CTS_CLKSEL_MSB:CTS_CLKSEL_LSB]),
        .pwm_mode(mode == cts_mode_pwm),
        .divider_stage_select(divider_stage_select),
        .low_freq_mode(low_freq_mode),
        .fs_tick(fs_tick),
        .count_input_pin(count_input_pin),
        .tick(tick)
    );

    // mode decode; event counting is timer mode fed by the count pin
    always_comb begin
        logic [2:0] low_mode;
        logic [2:0] up_mode;
        logic [2:0] src;
        low_mode = lower_unit_control[CTS_MODE_MSB:CTS_MODE_LSB];
        up_mode = upper_unit_control[CTS_MODE_MSB:CTS_MODE_LSB];
        src = lower_unit_control[CTS_CLKSEL_MSB:CTS_CLKSEL_LSB];
        mode = cts_mode_off;
        if (low_mode == CTS_LOW_CASCADE) begin
            if (up_mode == CTS_UP_PWM) begin
                mode = cts_mode_pwm;
            end else if (up_mode == CTS_UP_TIMER) begin
                mode = (src == CTS_SRC_EXT) ? cts_mode_event :
                                              cts_mode_timer;
            end
        end
        running = upper_unit_control[CTS_RUN_BIT] &&
                  (mode != cts_mode_off);
    end

    always_comb begin
        logic [8:0] sum_low;
        logic [7:0] inc_high;
        logic [15:0] count;
        logic duty_hit;
        logic ovf;
        count = {count_high, count_low};
        // low byte carry steps the high byte
        sum_low = {1'b0, count_low} + 9'h001;
        inc_high = count_high + {7'h00, sum_low[8]};
        duty_hit = (count == duty_reg);
        ovf = (count == CTS_COUNT_MAX);

        next_lower_ctl = lower_unit_control;
        next_upper_ctl = upper_unit_control;
        next_period = period_reg;
        next_duty = duty_reg;
        next_duty_stage_low = duty_stage_low;
        next_duty_shift = duty_shift;
        next_count_low = count_low;
        next_count_high = count_high;
        next_ff = output_flipflop;
        next_irq = 1'b0;

        // counting
        if (!running) begin
            // stopped: counter cleared, flip-flop holds its level
            next_count_low = '0;
            next_count_high = '0;
        end else if (tick) begin
            if (mode == cts_mode_pwm) begin
                // a duty match and overflow together cancel out
                next_ff = output_flipflop ^ duty_hit ^ ovf;
                if (ovf) begin
                    next_count_low = '0;
                    next_count_high = '0;
                    next_irq = 1'b1;
                    next_duty = duty_shift;
                end else begin
                    next_count_low = sum_low[7:0];
                    next_count_high = inc_high;
                end
            end else if (count == period_reg) begin
                next_count_low = '0;
                next_count_high = '0;
                next_irq = 1'b1;
            end else begin
                next_count_low = sum_low[7:0];
                next_count_high = inc_high;
            end
        end

        // register writes; a buffered duty reaches the active register
        // at the interrupt, so a write on that edge lands next period
        if (reg_wr.valid) begin
            unique case (reg_wr.sel)
                cts_sel_period_low: next_period[7:0] = reg_wr.data;
                cts_sel_period_high: next_period[15:8] = reg_wr.data;
                cts_sel_duty_low: next_duty_stage_low = reg_wr.data;
                cts_sel_duty_high: begin
                    next_duty_shift = {reg_wr.data, duty_stage_low};
                    if (!(running && mode == cts_mode_pwm)) begin
                        next_duty = {reg_wr.data, duty_stage_low};
                    end
                end
                cts_sel_lower_ctl: next_lower_ctl = reg_wr.data;
                cts_sel_upper_ctl: begin
                    next_upper_ctl = reg_wr.data;
                    // init level only taken while already stopped
                    if (!upper_unit_control[CTS_RUN_BIT] &&
                        !reg_wr.data[CTS_RUN_BIT]) begin
                        next_ff = reg_wr.data[CTS_FF_BIT];
                    end
                end
                default: ;
            endcase
        end
        next_pin = !next_ff;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lower_unit_control <= CTS_CTL_RESET;
            upper_unit_control <= CTS_CTL_RESET;
            period_reg <= CTS_PERIOD_RESET;
            duty_reg <= CTS_DUTY_RESET;
            duty_stage_low <= '0;
            duty_shift <= CTS_DUTY_RESET;
            count_low <= '0;
            count_high <= '0;
            output_flipflop <= 1'b0;
            pwm_output_pin <= 1'b1;
            cascade_interrupt <= 1'b0;
        end else begin
            lower_unit_control <= next_lower_ctl;
            upper_unit_control <= next_upper_ctl;
            period_reg <= next_period;
            duty_reg <= next_duty;
            duty_stage_low <= next_duty_stage_low;
            duty_shift <= next_duty_shift;
            count_low <= next_count_low;
            count_high <= next_count_high;
            output_flipflop <= next_ff;
            pwm_output_pin <= next_pin;
            cascade_interrupt <= next_irq;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count_value <= '0;
        end else begin
            count_value <= {next_count_high, next_count_low};
        end
    end
endmodule // cts_timer16

// >>> inc/cts_pkg.sv
// Purpose: shared constants and types of the cascaded 16-bit timer/PWM
// Assumes: one system clock (fc), fs arrives as a one-cycle tick
// Notes: control encodings describe the two 8-bit control bytes
package cts_pkg;

    // lower control byte
    localparam logic [2:0] CTS_LOW_CASCADE = 3'h3;
    localparam int CTS_MODE_LSB = 0;
    localparam int CTS_MODE_MSB = 2;
    localparam int CTS_CLKSEL_LSB = 4;
    localparam int CTS_CLKSEL_MSB = 6;

    // upper control byte
    localparam logic [2:0] CTS_UP_TIMER = 3'h4;
    localparam logic [2:0] CTS_UP_PWM = 3'h6;
    localparam int CTS_RUN_BIT = 3;
    localparam int CTS_FF_BIT = 7;

    // source clock select codes
    localparam logic [2:0] CTS_SRC_DIV11 = 3'h0;
    localparam logic [2:0] CTS_SRC_DIV7 = 3'h1;
    localparam logic [2:0] CTS_SRC_DIV5 = 3'h2;
    localparam logic [2:0] CTS_SRC_DIV3 = 3'h3;
    localparam logic [2:0] CTS_SRC_FS = 3'h4;
    localparam logic [2:0] CTS_SRC_DIV1 = 3'h5;
    localparam logic [2:0] CTS_SRC_FC = 3'h6;
    localparam logic [2:0] CTS_SRC_EXT = 3'h7;

    // divider exponents
    localparam int CTS_EXP11 = 11;
    localparam int CTS_EXP7 = 7;
    localparam int CTS_EXP5 = 5;
    localparam int CTS_EXP3 = 3;
    localparam int CTS_EXP1 = 1;
    localparam int CTS_FS_EXP = 3;

    // reset values and counter maximum
    localparam logic [7:0] CTS_CTL_RESET = 8'h00;
    localparam logic [15:0] CTS_PERIOD_RESET = 16'hffff;
    localparam logic [15:0] CTS_DUTY_RESET = 16'h0000;
    localparam logic [15:0] CTS_COUNT_MAX = 16'hffff;

    typedef enum logic [2:0] {
        cts_sel_period_low,
        cts_sel_period_high,
        cts_sel_duty_low,
        cts_sel_duty_high,
        cts_sel_lower_ctl,
        cts_sel_upper_ctl
    } cts_reg_sel_t;

    typedef struct packed {
        logic valid;
        cts_reg_sel_t sel;
        logic [7:0] data;
    } cts_wr_t;

    typedef enum logic [1:0] {
        cts_mode_off,
        cts_mode_timer,
        cts_mode_event,
        cts_mode_pwm
    } cts_mode_t;

endpackage

// >>> rtl/cts_prescaler.sv
// Purpose: source clock selection, yields one count tick per source period
// Assumes: fs_tick and count_input_pin are synchronous to clock
// Notes: tick is registered, so counting lags the source by one cycle
`timescale 1ns/1ps
module cts_prescaler
    import cts_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // selection
    input wire logic [2:0] clock_select,
    input wire logic pwm_mode,
    input wire logic divider_stage_select,
    input wire logic low_freq_mode,
    // sources
    input wire logic fs_tick,
    input wire logic count_input_pin,
    // result
    output logic tick
);
    logic [CTS_EXP11-1:0] div;
    logic [CTS_FS_EXP-1:0] fs_div;
    logic pin_prev;
    logic [CTS_EXP11-1:0] next_div;
    logic [CTS_FS_EXP-1:0] next_fs_div;
    logic next_tick;

    function automatic logic div_tick(input logic [CTS_EXP11-1:0] d,
                                      input int e);
        logic [CTS_EXP11-1:0] mask;
        mask = CTS_EXP11'((1 << e) - 1);
        return (d & mask) == mask;
    endfunction

    always_comb begin
        logic fs8;
        logic pin_fall;
        fs8 = fs_tick && (fs_div == '1);
        pin_fall = pin_prev && !count_input_pin;
        next_div = div + 1'b1;
        next_fs_div = fs_tick ? fs_div + 1'b1 : fs_div;
        next_tick = 1'b0;
        if (low_freq_mode) begin
            // slow clock only: fs/8, fs itself in pwm, and the count pin
            if (clock_select == CTS_SRC_DIV11) begin
                next_tick = fs8;
            end else if (clock_select == CTS_SRC_FS && pwm_mode) begin
                next_tick = fs_tick;
            end else if (clock_select == CTS_SRC_EXT) begin
                next_tick = pin_fall;
            end
        end else begin
            unique case (clock_select)
                CTS_SRC_DIV11: next_tick = divider_stage_select ? fs8 :
                                   div_tick(div, CTS_EXP11);
                CTS_SRC_DIV7: next_tick = div_tick(div, CTS_EXP7);
                CTS_SRC_DIV5: next_tick = div_tick(div, CTS_EXP5);
                CTS_SRC_DIV3: next_tick = div_tick(div, CTS_EXP3);
                CTS_SRC_FS: next_tick = pwm_mode && fs_tick;
                CTS_SRC_DIV1: next_tick = pwm_mode &&
                                  div_tick(div, CTS_EXP1);
                CTS_SRC_FC: next_tick = pwm_mode;
                CTS_SRC_EXT: next_tick = pin_fall;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            div <= '0;
            fs_div <= '0;
            pin_prev <= 1'b1;
            tick <= 1'b0;
        end else begin
            div <= next_div;
            fs_div <= next_fs_div;
            pin_prev <= count_input_pin;
            tick <= next_tick;
        end
    end
endmodule // cts_prescaler

// >>> dv/cts_timer16_checker.sv
// Purpose: port-level assertions for the cascaded timer
// Assumes: sees only the timer ports, one clock domain
// Notes: readback ports stand in for the internal registers
`timescale 1ns/1ps
module cts_timer16_checker
    import cts_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // writes
    input wire cts_wr_t reg_wr,
    // outputs
    input wire logic pwm_output_pin,
    input wire logic cascade_interrupt,
    input wire logic [7:0] lower_unit_control,
    input wire logic [7:0] upper_unit_control,
    input wire logic [15:0] period_reg,
    input wire logic [15:0] duty_reg,
    input wire logic [15:0] count_value,
    input wire logic output_flipflop
);
    logic stopped;
    logic pwm_run;
    logic up_wr;
    assign stopped = !upper_unit_control[CTS_RUN_BIT];
    assign pwm_run = !stopped && upper_unit_control[2:0] == CTS_UP_PWM
        && lower_unit_control[2:0] == CTS_LOW_CASCADE;
    assign up_wr = reg_wr.valid && reg_wr.sel == cts_sel_upper_ctl;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_pin_inverse: assert property (pwm_output_pin == !output_flipflop)
        else $error("pwm pin not inverse of flip-flop");
    a_irq_pulse: assert property (cascade_interrupt |=> !cascade_interrupt)
        else $error("interrupt longer than one cycle");
    a_irq_clear: assert property (cascade_interrupt |-> count_value == 16'h0)
        else $error("counter not cleared with interrupt");
    a_irq_run: assert property (cascade_interrupt |-> $past(!stopped))
        else $error("interrupt while stopped");
    a_count_step: assert property (1'b1 |=> count_value == 16'h0
        || count_value == $past(count_value)
        || count_value == $past(count_value) + 16'h1)
        else $error("counter jumped");
    a_stop_clear: assert property (stopped |=> count_value == 16'h0)
        else $error("counter runs while stopped");
    a_stop_freeze: assert property (stopped && !up_wr |=>
        $stable(output_flipflop)) else $error("flip-flop moved while stopped");
    a_ff_load: assert property (up_wr && stopped && !reg_wr.data[CTS_RUN_BIT]
        |=> output_flipflop == $past(reg_wr.data[CTS_FF_BIT]))
        else $error("flip-flop not loaded");
    a_period_now: assert property (reg_wr.valid
        && reg_wr.sel == cts_sel_period_low
        |=> period_reg[7:0] == $past(reg_wr.data)) else $error("period late");
    a_duty_hold: assert property (pwm_run ##1 !cascade_interrupt
        |-> $stable(duty_reg)) else $error("duty changed mid period");
    a_duty_stopped: assert property (stopped && reg_wr.valid
        && reg_wr.sel == cts_sel_duty_high
        |=> duty_reg[15:8] == $past(reg_wr.data)) else $error("duty late");
endmodule // cts_timer16_checker

// >>> dv/cts_pulse_source.sv
// Purpose: external pulse source feeding the count pin
// Assumes: half is at least two cycles
// Notes: holds its level while disabled, high out of reset, so no falling edge appears while disabled
`timescale 1ns/1ps
module cts_pulse_source (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // control
    input wire logic enable,
    input wire logic [2:0] half,
    // pin
    output logic count_input_pin
);
    logic [2:0] held;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            held <= 3'h0;
            count_input_pin <= 1'b1;
        end else if (enable && held + 3'h1 >= half) begin
            held <= 3'h0;
            count_input_pin <= ~count_input_pin;
        end else if (enable) begin
            held <= held + 3'h1;
        end
    end
endmodule // cts_pulse_source

// >>> dv/tb_cts_timer16.sv
// Purpose: self-checking bench of the cascaded timer
// Assumes: fs arrives as one tick every four cycles
// Notes: pwm runs on fc, so one pwm period costs 65536 cycles
`timescale 1ns/1ps
module tb_cts_timer16;
    import cts_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    cts_wr_t reg_wr = '0;
    logic divider_stage_select = 1'b0;
    logic low_freq_mode = 1'b0;
    logic fs_tick = 1'b0;
    logic src_en = 1'b0;
    logic [2:0] half = 3'h2;
    logic count_input_pin, pwm_output_pin, cascade_interrupt, output_flipflop;
    logic [7:0] lower_unit_control, upper_unit_control;
    logic [15:0] period_reg, duty_reg, count_value;
    logic pin_held;
    int err_total = 0;
    int n_compared = 0;
    int cyc = 0;
    int t0, t1, p, q, d, n;
    // source table: select, expected cycles per tick (0 = no ticks)
    localparam int DIV_T [7] = '{2048, 32, 128, 32, 8, 32, 0};
    localparam logic [2:0] SEL_T [7] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3,
        3'h0, 3'h3};
    localparam logic [6:0] DSS_T = 7'h02;
    localparam logic [6:0] LF_T = 7'h60;

    cts_timer16 DUT (.clock, .rst, .reg_wr, .divider_stage_select,
        .low_freq_mode, .fs_tick, .count_input_pin, .pwm_output_pin,
        .cascade_interrupt, .lower_unit_control, .upper_unit_control,
        .period_reg, .duty_reg, .count_value, .output_flipflop);
    cts_pulse_source u_src (.clock, .rst, .enable(src_en), .half,
        .count_input_pin);

    always #25 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        fs_tick <= (cyc % 4 == 3);
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wr(input cts_reg_sel_t sel, input logic [7:0] data);
        @(posedge clock);
        reg_wr <= '{1'b1, sel, data};
        @(posedge clock);
        reg_wr <= '0;
    endtask
    // low byte first, both bytes always
    task automatic wr16(input cts_reg_sel_t lo, input logic [15:0] v);
        wr(lo, v[7:0]);
        wr(cts_reg_sel_t'(lo + 1), v[15:8]);
    endtask
    task automatic wait_irq(input int lim, output int t);
        t = -1;
        for (int i = 0; i < lim && t < 0; i++) begin
            @(negedge clock);
            if (cascade_interrupt === 1'b1) t = cyc;
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    initial begin
        void'($urandom(32'h54a3cca4));
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk(pwm_output_pin, 1'b1);
        chk(period_reg, CTS_PERIOD_RESET);
        for (int i = 0; i < 7; i++) begin
            p = 1 + $urandom % 3;
            q = 1 + $urandom % 3;
            @(posedge clock);
            divider_stage_select <= DSS_T[i];
            low_freq_mode <= LF_T[i];
            wr(cts_sel_upper_ctl, 8'h04);
            wr16(cts_sel_period_low, p[15:0]);
            wr(cts_sel_lower_ctl, {1'b0, SEL_T[i], 4'h3});
            wr(cts_sel_upper_ctl, 8'h0c);
            wait_irq(5 * DIV_T[i] + 300, t0);
            wr16(cts_sel_period_low, q[15:0]);
            wait_irq(5 * DIV_T[i] + 300, t1);
            if (DIV_T[i] == 0) chk(t0, 32'hffffffff);
            else chk(t1 - t0, (q + 1) * DIV_T[i]);
        end
        @(posedge clock);
        low_freq_mode <= 1'b0;
        half <= 3'h2 + 3'($urandom % 3);
        src_en <= 1'b1;
        wr(cts_sel_upper_ctl, 8'h04);
        wr(cts_sel_lower_ctl, 8'h73);
        wr(cts_sel_upper_ctl, 8'h0c);
        wait_irq(400, t0);
        wait_irq(400, t1);
        chk(t1 - t0, (q + 1) * 2 * half);
        d = 16'h0100 + $urandom % 16'h7000;
        n = 16'h0100 + $urandom % 16'h7000;
        wr(cts_sel_upper_ctl, 8'h06);
        wr16(cts_sel_duty_low, d[15:0]);
        @(negedge clock);
        chk(duty_reg, d[15:0]);
        wr(cts_sel_lower_ctl, 8'h63);
        wr(cts_sel_upper_ctl, 8'h0e);
        @(negedge clock);
        chk(lower_unit_control, 8'h63);
        chk(upper_unit_control, 8'h0e);
        wr16(cts_sel_duty_low, n[15:0]);
        @(negedge clock);
        chk(duty_reg, d[15:0]);
        for (t0 = 0; t0 < 70000 && output_flipflop !== 1'b1; t0++)
            @(negedge clock);
        t0 = cyc;
        wait_irq(70000, t1);
        chk(t1 - t0, 65535 - d);
        chk(duty_reg, n[15:0]);
        chk(output_flipflop, 1'b0);
        // stop before any low-power entry, so no stray pulse on wake
        wr(cts_sel_upper_ctl, 8'h06);
        pin_held = pwm_output_pin;
        repeat (20) @(negedge clock);
        chk(pwm_output_pin, pin_held);
        chk(count_value, 16'h0000);
        wr(cts_sel_upper_ctl, 8'h86);
        @(negedge clock);
        chk(output_flipflop, 1'b1);
        // pin level as seen with the port output latch already at 1
        chk(pwm_output_pin, 1'b0);
        chk(upper_unit_control, 8'h86);
        print_verdict();
    end

    // longest path is the pwm period plus the slow timer source
    initial begin
        #6000000;
        err_total++;
        print_verdict();
    end
endmodule // tb_cts_timer16

bind cts_timer16 cts_timer16_checker u_chk (.clock, .rst, .reg_wr,
    .pwm_output_pin, .cascade_interrupt, .lower_unit_control,
    .upper_unit_control, .period_reg, .duty_reg, .count_value,
    .output_flipflop);
